// file: pkg/skip_test_pkg.sv
// package for the flag-set and skip-test decoder
// assumes a 10-bit instruction word and 4-bit data path
package skip_test_pkg;

  localparam logic [9:0] OP_SET_CARRY     = 10'h007;
  localparam logic [9:0] OP_SET_PORT_BIT  = 10'h015;
  localparam logic [9:0] OP_CMP_IMM       = 10'h025;
  localparam logic [9:0] OP_CMP_MEM       = 10'h026;
  localparam logic [9:0] OP_EXT_REQ_TEST  = 10'h038;
  localparam logic [9:0] OP_CONV_TEST     = 10'h287;
  localparam logic [9:0] OP_PIN_TEST      = 10'h03a;
  localparam logic [9:0] OP_PDOWN_TEST    = 10'h003;
  localparam logic [9:0] OP_SERIAL_TEST   = 10'h288;
  localparam logic [9:0] OP_TIMER1_TEST   = 10'h280;
  localparam logic [9:0] OP_TIMER2_TEST   = 10'h281;

  localparam int EXT_IRQ_EN_POS    = 0;
  localparam int TIMER1_IRQ_EN_POS = 2;
  localparam int TIMER2_IRQ_EN_POS = 3;
  localparam int CONV_IRQ_EN_POS   = 2;
  localparam int SERIAL_IRQ_EN_POS = 3;
  localparam int PIN_POLARITY_POS  = 2;

  localparam logic [3:0] PORT_RESET  = 4'h0;
  localparam logic       CARRY_RESET = 1'b0;
  localparam logic [1:0] PORT_BIT_MAX = 2'h3;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_IMM,
    ST_SKIP
  } exec_state_type;

endpackage : skip_test_pkg

// file: hdl/flag_clear_ctl.sv
// flag clear request generator for one request flag
// assumes the flag source clears on a one-cycle pulse and lets a new set win
`timescale 1ns/10ps
module flag_clear_ctl
  import skip_test_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic exec_test,
  input  wire logic irq_enable,
  input  wire logic flag_level,
  output logic      clear_pulse,
  output logic      skip_hit
);

  logic active;

  // enabled interrupt turns the test into a no-operation
  assign active      = exec_test & ~irq_enable;
  assign clear_pulse = active;
  assign skip_hit    = active & flag_level;

  property p_noop_when_enabled;
    @(posedge ref_clk) disable iff (srst)
    irq_enable |-> !clear_pulse && !skip_hit;
  endproperty
  a_noop_when_enabled: assert property (p_noop_when_enabled)
    else $error("clear or skip while interrupt enabled");

endmodule : flag_clear_ctl

// file: hdl/skip_test_decoder.sv
// flag-set and skip-test instruction executor of a 4-bit core
// assumes one instruction word presented per cycle with instr_valid;
// request flags live outside and clear on the pulses given here
//
// Behaviour
// - set-carry forces carry to 1, one word one cycle, nothing else changes
// - set-port-bit drives to 1 the port D bit chosen by a bit select of 0 to 3
// - compare-memory skips when accumulator equals memory nibble at data pointer
// - ext enable 0: ext test clears request flag, skips if it was 1
// - ext enable 1: ext test is a no-operation
// - converter enable 0: converter test clears flag, skips if it was 1
// - converter enable 1: converter test is a no-operation
// - pin test skips on low pin when polarity is 0, or on high pin when polarity is 1
// - power-down test skips when flag is 1, never changes the flag
// - serial enable 0: clear flag, skip if set; enable 1: no-operation
// - timer 1 enable 0: clear flag, skip if set; enable 1: no-operation
// - timer 2 enable 0: clear flag, skip if set; enable 1: no-operation
`timescale 1ns/10ps
module skip_test_decoder
  import skip_test_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       instr_valid,
  input  wire logic [9:0] instr_word,
  input  wire logic [3:0] accumulator,
  input  wire logic [3:0] mem_nibble,
  input  wire logic [2:0] bit_select,
  input  wire logic [3:0] irq_ctrl1,
  input  wire logic [3:0] irq_ctrl2,
  input  wire logic [3:0] pin_ctrl,
  input  wire logic       ext_irq_pin,
  input  wire logic       power_down_flag,
  input  wire logic       ext_request_flag,
  input  wire logic       converter_completion_flag,
  input  wire logic       serial_completion_flag,
  input  wire logic       first_timer_request_flag,
  input  wire logic       second_timer_request_flag,
  output logic            carry_flag,
  output logic [3:0]      port_d,
  output logic            ext_request_clear,
  output logic            converter_clear,
  output logic            serial_clear,
  output logic            first_timer_clear,
  output logic            second_timer_clear,
  output logic            instr_suppressed,
  output logic            skip_pending
);

  exec_state_type state_r, state_nxt;
  logic           carry_r, carry_nxt;
  logic [3:0]     port_r, port_nxt;
  logic [3:0]     imm_acc_r;
  logic           pin_meta_r, pin_sync_r;
  logic           pdown_meta_r, pdown_sync_r;

  function automatic logic is_op(input logic [9:0] w, input logic [9:0] op);
    return w == op;
  endfunction : is_op

  wire execute   = instr_valid & (state_r == ST_FETCH);
  wire do_carry  = execute & is_op(instr_word, OP_SET_CARRY);
  wire do_port   = execute & is_op(instr_word, OP_SET_PORT_BIT);
  wire do_cmpi   = execute & is_op(instr_word, OP_CMP_IMM);
  wire do_cmpm   = execute & is_op(instr_word, OP_CMP_MEM);
  wire do_ext    = execute & is_op(instr_word, OP_EXT_REQ_TEST);
  wire do_conv   = execute & is_op(instr_word, OP_CONV_TEST);
  wire do_pin    = execute & is_op(instr_word, OP_PIN_TEST);
  wire do_pdown  = execute & is_op(instr_word, OP_PDOWN_TEST);
  wire do_serial = execute & is_op(instr_word, OP_SERIAL_TEST);
  wire do_t1     = execute & is_op(instr_word, OP_TIMER1_TEST);
  wire do_t2     = execute & is_op(instr_word, OP_TIMER2_TEST);

  logic ext_hit, conv_hit, ser_hit, t1_hit, t2_hit;

  flag_clear_ctl u_ext (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .exec_test   (do_ext),
    .irq_enable  (irq_ctrl1[EXT_IRQ_EN_POS]),
    .flag_level  (ext_request_flag),
    .clear_pulse (ext_request_clear),
    .skip_hit    (ext_hit)
  );

  flag_clear_ctl u_conv (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .exec_test   (do_conv),
    .irq_enable  (irq_ctrl2[CONV_IRQ_EN_POS]),
    .flag_level  (converter_completion_flag),
    .clear_pulse (converter_clear),
    .skip_hit    (conv_hit)
  );

  flag_clear_ctl u_ser (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .exec_test   (do_serial),
    .irq_enable  (irq_ctrl2[SERIAL_IRQ_EN_POS]),
    .flag_level  (serial_completion_flag),
    .clear_pulse (serial_clear),
    .skip_hit    (ser_hit)
  );

  flag_clear_ctl u_t1 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .exec_test   (do_t1),
    .irq_enable  (irq_ctrl1[TIMER1_IRQ_EN_POS]),
    .flag_level  (first_timer_request_flag),
    .clear_pulse (first_timer_clear),
    .skip_hit    (t1_hit)
  );

  flag_clear_ctl u_t2 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .exec_test   (do_t2),
    .irq_enable  (irq_ctrl1[TIMER2_IRQ_EN_POS]),
    .flag_level  (second_timer_request_flag),
    .clear_pulse (second_timer_clear),
    .skip_hit    (t2_hit)
  );

  // pin and power-down flag are asynchronous, so both pass two flops first
  wire pin_hit   = do_pin & (pin_sync_r == pin_ctrl[PIN_POLARITY_POS]);
  wire pdown_hit = do_pdown & pdown_sync_r;
  wire mem_hit   = do_cmpm & (accumulator == mem_nibble);
  wire imm_hit   = (state_r == ST_IMM) & instr_valid
                   & (instr_word[3:0] == imm_acc_r);

  wire skip_set  = ext_hit | conv_hit | ser_hit | t1_hit | t2_hit
                   | pin_hit | pdown_hit | mem_hit | imm_hit;

  // bit select above 3 is illegal; such a set-port-bit leaves port D unchanged
  wire port_ok   = (bit_select <= {1'b0, PORT_BIT_MAX});

  always_comb begin
    state_nxt = state_r;
    carry_nxt = carry_r;
    port_nxt  = port_r;
    if (do_carry) begin
      carry_nxt = 1'b1;
    end
    if (do_port && port_ok) begin
      port_nxt[bit_select[1:0]] = 1'b1;
    end
    case (state_r)
      ST_FETCH: begin
        if (do_cmpi) begin
          state_nxt = ST_IMM;
        end else if (skip_set) begin
          state_nxt = ST_SKIP;
        end
      end
      ST_IMM: begin
        if (instr_valid) begin
          state_nxt = imm_hit ? ST_SKIP : ST_FETCH;
        end
      end
      ST_SKIP: begin
        // next word is fetched and burns its cycle but does nothing
        if (instr_valid) begin
          state_nxt = ST_FETCH;
        end
      end
      default: state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_FETCH;
      carry_r <= CARRY_RESET;
      port_r  <= PORT_RESET;
    end else begin
      state_r <= state_nxt;
      carry_r <= carry_nxt;
      port_r  <= port_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      imm_acc_r <= 4'h0;
    end else if (do_cmpi) begin
      imm_acc_r <= accumulator;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta_r   <= 1'b0;
      pin_sync_r   <= 1'b0;
      pdown_meta_r <= 1'b0;
      pdown_sync_r <= 1'b0;
    end else begin
      pin_meta_r   <= ext_irq_pin;
      pin_sync_r   <= pin_meta_r;
      pdown_meta_r <= power_down_flag;
      pdown_sync_r <= pdown_meta_r;
    end
  end

  assign carry_flag       = carry_r;
  assign port_d           = port_r;
  assign instr_suppressed = (state_r == ST_SKIP) & instr_valid;
  assign skip_pending     = (state_r == ST_SKIP);

  property p_carry_set;
    @(posedge ref_clk) disable iff (srst)
    do_carry |=> carry_flag;
  endproperty
  a_carry_set: assert property (p_carry_set)
    else $error("carry not set");

  property p_carry_hold;
    @(posedge ref_clk) disable iff (srst)
    !do_carry |=> carry_flag == $past(carry_flag);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("carry changed without set");

  property p_port_bit;
    @(posedge ref_clk) disable iff (srst)
    do_port && port_ok |=> port_d[$past(bit_select[1:0])];
  endproperty
  a_port_bit: assert property (p_port_bit)
    else $error("port bit not set");

  property p_cmp_imm_two;
    @(posedge ref_clk) disable iff (srst)
    do_cmpi |=> state_r == ST_IMM;
  endproperty
  a_cmp_imm_two: assert property (p_cmp_imm_two)
    else $error("immediate word not taken");

  property p_cmp_mem;
    @(posedge ref_clk) disable iff (srst)
    do_cmpm && accumulator == mem_nibble |=> skip_pending;
  endproperty
  a_cmp_mem: assert property (p_cmp_mem)
    else $error("memory compare did not skip");

  property p_cmp_mem_miss;
    @(posedge ref_clk) disable iff (srst)
    do_cmpm && accumulator != mem_nibble |=> !skip_pending;
  endproperty
  a_cmp_mem_miss: assert property (p_cmp_mem_miss)
    else $error("memory compare skipped on mismatch");

  property p_ext_skip;
    @(posedge ref_clk) disable iff (srst)
    do_ext && !irq_ctrl1[EXT_IRQ_EN_POS] |-> ext_request_clear
      ##1 (skip_pending == $past(ext_request_flag));
  endproperty
  a_ext_skip: assert property (p_ext_skip)
    else $error("ext test wrong");

  property p_ext_noop;
    @(posedge ref_clk) disable iff (srst)
    do_ext && irq_ctrl1[EXT_IRQ_EN_POS] |-> !ext_request_clear ##1 !skip_pending;
  endproperty
  a_ext_noop: assert property (p_ext_noop)
    else $error("ext test not a no-operation");

  // converter, serial and timer tests share the clear-and-skip shape of the ext test
  property p_conv_skip;
    @(posedge ref_clk) disable iff (srst)
    do_conv && !irq_ctrl2[CONV_IRQ_EN_POS] |-> converter_clear
      ##1 (skip_pending == $past(converter_completion_flag));
  endproperty
  a_conv_skip: assert property (p_conv_skip)
    else $error("converter test wrong");

  property p_serial_skip;
    @(posedge ref_clk) disable iff (srst)
    do_serial && !irq_ctrl2[SERIAL_IRQ_EN_POS] |-> serial_clear
      ##1 (skip_pending == $past(serial_completion_flag));
  endproperty
  a_serial_skip: assert property (p_serial_skip)
    else $error("serial test wrong");

  property p_t1_skip;
    @(posedge ref_clk) disable iff (srst)
    do_t1 && !irq_ctrl1[TIMER1_IRQ_EN_POS] |-> first_timer_clear
      ##1 (skip_pending == $past(first_timer_request_flag));
  endproperty
  a_t1_skip: assert property (p_t1_skip)
    else $error("timer 1 test wrong");

  property p_t2_skip;
    @(posedge ref_clk) disable iff (srst)
    do_t2 && !irq_ctrl1[TIMER2_IRQ_EN_POS] |-> second_timer_clear
      ##1 (skip_pending == $past(second_timer_request_flag));
  endproperty
  a_t2_skip: assert property (p_t2_skip)
    else $error("timer 2 test wrong");

  property p_pin_skip;
    @(posedge ref_clk) disable iff (srst)
    do_pin |=> skip_pending == $past(pin_sync_r == pin_ctrl[PIN_POLARITY_POS]);
  endproperty
  a_pin_skip: assert property (p_pin_skip)
    else $error("pin test wrong");

  property p_pdown;
    @(posedge ref_clk) disable iff (srst)
    do_pdown |=> skip_pending == $past(pdown_sync_r);
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power-down test wrong");

  property p_skip_one;
    @(posedge ref_clk) disable iff (srst)
    skip_pending && instr_valid |=> !skip_pending;
  endproperty
  a_skip_one: assert property (p_skip_one)
    else $error("skip lasted past one instruction");

endmodule : skip_test_decoder

// file: test/prog_stream.sv
// program memory model feeding the decoder one word per cycle
// assumes the bench asks for a fetch just after a rising edge
`timescale 1ns/10ps
module prog_stream (
  input  wire logic       ref_clk,
  input  wire logic       fetch,
  input  wire logic [9:0] word_in,
  output logic            instr_valid,
  output logic [9:0]      instr_word
);
  initial instr_word = 10'h000;
  initial instr_valid = 1'b0;
  // idle word flips every cycle so a stale opcode is never mistaken for a fresh one
  always @(posedge ref_clk) begin
    instr_valid <= fetch;
    instr_word  <= fetch ? word_in : ~instr_word;
  end
endmodule : prog_stream

// file: test/tb_flag_set_and_skip_test_instructions.sv
// self-checking bench for the flag-set and skip-test decoder
// assumes the program stream model sits in front of instr_valid and instr_word
`timescale 1ns/10ps
module tb_flag_set_and_skip_test_instructions;
  import skip_test_pkg::*;
  logic        ref_clk, srst, fetch, instr_valid, ext_irq_pin, power_down_flag;
  logic        ext_f, conv_f, ser_f, t1_f, t2_f;
  logic        carry_flag, instr_suppressed, skip_pending, cy_exp;
  logic [9:0]  word_in, instr_word;
  logic [3:0]  accumulator, mem_nibble, irq_ctrl1, irq_ctrl2, pin_ctrl, port_d, pd_exp;
  logic [2:0]  bit_select;
  logic [4:0]  clrs;
  logic [31:0] r;
  int          n_mismatch, compares, seed, i, k;

  prog_stream src (.ref_clk(ref_clk), .fetch(fetch), .word_in(word_in),
    .instr_valid(instr_valid), .instr_word(instr_word));

  skip_test_decoder dut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
    .instr_word(instr_word), .accumulator(accumulator), .mem_nibble(mem_nibble),
    .bit_select(bit_select), .irq_ctrl1(irq_ctrl1), .irq_ctrl2(irq_ctrl2),
    .pin_ctrl(pin_ctrl), .ext_irq_pin(ext_irq_pin), .power_down_flag(power_down_flag),
    .ext_request_flag(ext_f), .converter_completion_flag(conv_f),
    .serial_completion_flag(ser_f), .first_timer_request_flag(t1_f),
    .second_timer_request_flag(t2_f), .carry_flag(carry_flag), .port_d(port_d),
    .ext_request_clear(clrs[0]), .converter_clear(clrs[1]), .serial_clear(clrs[2]),
    .first_timer_clear(clrs[3]), .second_timer_clear(clrs[4]),
    .instr_suppressed(instr_suppressed), .skip_pending(skip_pending));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic exp_skip(input logic en, input logic f);
    return !en && f;
  endfunction : exp_skip

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // op, optional operand word, then a set-carry that shows whether it was suppressed
  task automatic run(input logic [9:0] op, input logic two, input logic [3:0] n,
                     input logic sk, input logic [4:0] msk, input logic [4:0] ec);
    @(posedge ref_clk) #2 fetch = 1'b1;
    word_in = op;
    @(posedge ref_clk) #2 word_in = two ? {6'h00, n} : OP_SET_CARRY;
    #10 cmp(clrs & msk, ec & msk);
    if (two) begin
      @(posedge ref_clk) #2 word_in = OP_SET_CARRY;
    end
    @(posedge ref_clk) #2 fetch = 1'b0;
    #10 cmp(instr_suppressed, sk);
    cmp(skip_pending, sk);
    cmp(carry_flag, cy_exp | (op == OP_SET_CARRY));
    // carry only ever rises here, so a set-carry that was not suppressed leaves it at 1
    cy_exp = cy_exp | (op == OP_SET_CARRY) | !sk;
    @(posedge ref_clk) #12 cmp(carry_flag, cy_exp);
    cmp(skip_pending, 1'b0);
    $display("test op=%h done", op);
  endtask : run

  task automatic flag(input logic [9:0] op, input logic en, input logic f, input int idx);
    run(op, 1'b0, 4'h0, exp_skip(en, f), 5'h1f,
        en ? 5'h00 : 5'h01 << idx);
  endtask : flag

  initial begin
    #200000 n_mismatch++;
    give_verdict();
  end

  initial begin
    seed = 32'h111ed4af;
    n_mismatch = 0;
    compares = 0;
    cy_exp = 1'b0;
    {srst, fetch, word_in, accumulator, mem_nibble, bit_select} = 23'h400000;
    {irq_ctrl1, irq_ctrl2, pin_ctrl, ext_irq_pin, power_down_flag} = 14'h0002;
    {ext_f, conv_f, ser_f, t1_f, t2_f} = 5'h00;
    repeat (3) @(posedge ref_clk);
    #2 srst = 1'b0;
    run(OP_SET_CARRY, 1'b0, 4'h0, 1'b0, 5'h00, 5'h00);
    cmp(port_d, 4'h0);
    pd_exp = 4'h0;
    for (i = 0; i < 4; i++) begin
      bit_select = i[2:0];
      pd_exp[i] = 1'b1;
      run(OP_SET_PORT_BIT, 1'b0, 4'h0, 1'b0, 5'h00, 5'h00);
      cmp(port_d, pd_exp);
    end
    for (i = 0; i < 70; i++) begin
      @(posedge ref_clk) #2 srst = 1'b1;
      @(posedge ref_clk) #2 srst = 1'b0;
      cy_exp = 1'b0;
      r = $random(seed);
      {irq_ctrl1, irq_ctrl2, pin_ctrl, accumulator, mem_nibble} = r[19:0];
      if (r[20]) mem_nibble = accumulator;
      {ext_irq_pin, power_down_flag, ext_f, conv_f, ser_f, t1_f, t2_f} = r[27:21];
      k = r[31:29];
      // pin and power-down pass two sync flops before the test may see them
      repeat (3) @(posedge ref_clk);
      case (k)
        0: flag(OP_EXT_REQ_TEST, irq_ctrl1[EXT_IRQ_EN_POS], ext_f, 0);
        1: flag(OP_CONV_TEST, irq_ctrl2[CONV_IRQ_EN_POS], conv_f, 1);
        2: flag(OP_SERIAL_TEST, irq_ctrl2[SERIAL_IRQ_EN_POS], ser_f, 2);
        3: flag(OP_TIMER1_TEST, irq_ctrl1[TIMER1_IRQ_EN_POS], t1_f, 3);
        4: flag(OP_TIMER2_TEST, irq_ctrl1[TIMER2_IRQ_EN_POS], t2_f, 4);
        5: run(OP_PIN_TEST, 1'b0, 4'h0, ext_irq_pin == pin_ctrl[PIN_POLARITY_POS], 5'h00, 5'h00);
        6: run(OP_PDOWN_TEST, 1'b0, 4'h0, power_down_flag, 5'h00, 5'h00);
        default: begin
          if (r[28]) run(OP_CMP_MEM, 1'b0, 4'h0, accumulator == mem_nibble, 5'h00, 5'h00);
          else run(OP_CMP_IMM, 1'b1, mem_nibble, accumulator == mem_nibble, 5'h00, 5'h00);
        end
      endcase
    end
    give_verdict();
  end
endmodule : tb_flag_set_and_skip_test_instructions
